// ### logic/ocs_cycle_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module ocs_cycle_ctrl
  import ocs_pkg::*;
#(
  parameter int RESTART_QUAL_CYC_P = RESTART_QUAL_CYC
)
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  // comparators
  input  wire logic       output_voltage_sense_low_i,
  input  wire logic       output_restart_low_i,
  input  wire logic       below_cc_knee_i,
  input  wire logic       above_power_knee_i,
  input  wire logic       current_sense_over_i,
  input  wire logic       current_sense_surge_i,
  input  wire logic       sr_drop_below_i,
  // power stage events
  input  wire logic       current_limit_i,
  input  wire logic       limit_in_blank_i,
  input  wire logic       forward_winding_negedge_i,
  // gates and status
  output logic            power_switch_gate_o,
  output logic            sync_rectifier_gate_o,
  output logic      [3:0] limit_state_o,
  output logic            restart_o
);

  // ==========================================================
  // jittered oscillator
  // ==========================================================
  logic [CNT_W-1:0] per_cnt_r;
  logic [CNT_W-1:0] per_cnt_nxt;
  logic [CNT_W-1:0] per_len_r;
  logic [CNT_W-1:0] per_len_nxt;
  logic [7:0]       mod_cnt_r;
  logic [7:0]       mod_cnt_nxt;
  logic             mod_up_r;
  logic             mod_up_nxt;
  logic             tick;
  logic [CNT_W-1:0] jit_step;

  assign tick = (per_cnt_r == per_len_r - CNT_W'(1));

  // triangle sweep from the shortest to the longest period and back;
  // symmetric steps keep the mean period exactly on the average
  always_comb
  begin
    jit_step    = CNT_W'(JIT_STEP_BASE);
    if (mod_cnt_r < 8'(JIT_STEP_REM))
      jit_step  = CNT_W'(JIT_STEP_BASE + 1);
    per_cnt_nxt = tick ? '0 : per_cnt_r + CNT_W'(1);
    per_len_nxt = per_len_r;
    mod_cnt_nxt = mod_cnt_r;
    mod_up_nxt  = mod_up_r;
    if (tick)
    begin
      if (mod_cnt_r == 8'(MOD_PERIODS / 2 - 1))
      begin
        mod_cnt_nxt = 8'h00;
        mod_up_nxt  = !mod_up_r;
      end
      else
      begin
        mod_cnt_nxt = mod_cnt_r + 8'h01;
      end
      // full p-p swing covered in half a sweep
      if (mod_up_r)
        per_len_nxt = per_len_r + jit_step;
      else
        per_len_nxt = per_len_r - jit_step;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      per_cnt_r <= '0;
      per_len_r <= CNT_W'(PERIOD_CYC - JIT_CYC);
      mod_cnt_r <= 8'h00;
      mod_up_r  <= 1'b1;
    end
    else
    begin
      per_cnt_r <= per_cnt_nxt;
      per_len_r <= per_len_nxt;
      mod_cnt_r <= mod_cnt_nxt;
      mod_up_r  <= mod_up_nxt;
    end
  end

  // ==========================================================
  // limit history
  // ==========================================================
  logic       period_en;
  logic [3:0] on_count;

  ocs_hist_window u_hist (
    .clk_i      (clk_i),
    .reset_n_i  (reset_n_i),
    .tick_i     (tick),
    .enabled_i  (period_en),
    .on_count_o (on_count)
  );

  ocs_lim_t target_lim;

  always_comb
  begin
    if (on_count >= 4'(HIGH_ON_MIN))
      target_lim = LIM_HIGHEST;
    else if (on_count >= 4'(MED_ON_MIN))
      target_lim = LIM_MEDIUM;
    else if (on_count >= 4'(LOW_ON_MIN))
      target_lim = LIM_LOW;
    else
      target_lim = LIM_LIGHTEST;
  end

  // ==========================================================
  // cycle sequencing
  // ==========================================================
  ocs_phase_t       phase_r;
  ocs_phase_t       phase_nxt;
  ocs_lim_t         lim_r;
  ocs_lim_t         lim_nxt;
  logic [CNT_W-1:0] on_cnt_r;
  logic [CNT_W-1:0] on_cnt_nxt;
  logic [CNT_W-1:0] skip_cnt_r;
  logic [CNT_W-1:0] skip_cnt_nxt;
  logic [CNT_W-1:0] ar_cnt_r;
  logic [CNT_W-1:0] ar_cnt_nxt;
  logic             blank_hit_r;
  logic             blank_hit_nxt;
  logic             cc_skip_r;
  logic             cc_skip_nxt;
  logic             restart_r;
  logic             restart_nxt;
  logic             sw_r;
  logic             sw_nxt;
  logic             sr_r;
  logic             sr_nxt;
  logic             want;

  // constant current: every other requested cycle dropped on overrun
  // constant power above knee uses the same overrun pulse thinning
  always_comb
  begin
    want = output_voltage_sense_low_i;
    if (current_sense_over_i && (below_cc_knee_i || above_power_knee_i))
      want = want && !cc_skip_r;
    period_en = tick && want && !restart_r
                && (skip_cnt_r == '0);
  end

  always_comb
  begin
    phase_nxt     = phase_r;
    lim_nxt       = lim_r;
    on_cnt_nxt    = on_cnt_r;
    sw_nxt        = sw_r;
    sr_nxt        = sr_r;
    blank_hit_nxt = blank_hit_r;
    cc_skip_nxt   = cc_skip_r;
    skip_cnt_nxt  = (skip_cnt_r != '0) ? skip_cnt_r - CNT_W'(1) : '0;
    ar_cnt_nxt    = ar_cnt_r;
    restart_nxt   = restart_r;

    // long undervoltage gives up control until the output recovers
    if (output_restart_low_i)
    begin
      if (ar_cnt_r >= CNT_W'(RESTART_QUAL_CYC_P))
        restart_nxt = 1'b1;
      else
        ar_cnt_nxt = ar_cnt_r + CNT_W'(1);
    end
    else
    begin
      ar_cnt_nxt  = '0;
      restart_nxt = 1'b0;
    end

    if (tick && current_sense_over_i)
      cc_skip_nxt = !cc_skip_r;

    case (phase_r)
      PH_IDLE:
      begin
        if (period_en)
        begin
          sr_nxt     = 1'b0;
          sw_nxt     = 1'b1;
          lim_nxt    = target_lim;
          on_cnt_nxt = '0;
          phase_nxt  = PH_ON;
        end
        else if (tick)
        begin
          blank_hit_nxt = 1'b0;
        end
      end
      PH_ON:
      begin
        // comparator is not looked at here: cycle always completes
        on_cnt_nxt = on_cnt_r + CNT_W'(1);
        if (current_limit_i || on_cnt_r >= CNT_W'(MAX_ON_CYC - 1))
        begin
          sw_nxt    = 1'b0;
          phase_nxt = PH_SR;
          if (current_limit_i && limit_in_blank_i)
          begin
            blank_hit_nxt = 1'b1;
            if (blank_hit_r)
            begin
              skip_cnt_nxt  = CNT_W'(SOA_SKIP_CYC);
              blank_hit_nxt = 1'b0;
            end
          end
          else
          begin
            blank_hit_nxt = 1'b0;
          end
        end
      end
      PH_SR:
      begin
        if (forward_winding_negedge_i && !current_sense_surge_i)
          sr_nxt = 1'b1;
        phase_nxt = PH_IDLE;
        if (!forward_winding_negedge_i)
          phase_nxt = PH_SR;
        if (tick)
          phase_nxt = PH_IDLE;
      end
      default:
      begin
        phase_nxt = PH_IDLE;
        sw_nxt    = 1'b0;
        sr_nxt    = 1'b0;
      end
    endcase

    // rectifier release: drop comparator, surge, or next request
    if (sr_r && (sr_drop_below_i || current_sense_surge_i))
      sr_nxt = 1'b0;
    if (sr_r && period_en)
      sr_nxt = 1'b0;
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      phase_r     <= PH_IDLE;
      lim_r       <= LIM_HIGHEST;
      on_cnt_r    <= '0;
      skip_cnt_r  <= '0;
      ar_cnt_r    <= '0;
      blank_hit_r <= 1'b0;
      cc_skip_r   <= 1'b0;
      restart_r   <= 1'b0;
      sw_r        <= 1'b0;
      sr_r        <= 1'b0;
    end
    else
    begin
      phase_r     <= phase_nxt;
      lim_r       <= lim_nxt;
      on_cnt_r    <= on_cnt_nxt;
      skip_cnt_r  <= skip_cnt_nxt;
      ar_cnt_r    <= ar_cnt_nxt;
      blank_hit_r <= blank_hit_nxt;
      cc_skip_r   <= cc_skip_nxt;
      restart_r   <= restart_nxt;
      sw_r        <= sw_nxt;
      sr_r        <= sr_nxt;
    end
  end

  assign power_switch_gate_o   = sw_r;
  assign sync_rectifier_gate_o = sr_r;
  assign limit_state_o         = lim_r;
  assign restart_o             = restart_r;

endmodule
`default_nettype wire

// ### logic/ocs_hist_window.sv
`timescale 1ns/1ps
`default_nettype none
// shift register of enabled/skipped periods with a popcount
module ocs_hist_window
  import ocs_pkg::*;
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  // period sample
  input  wire logic       tick_i,
  input  wire logic       enabled_i,
  // history
  output logic      [3:0] on_count_o
);

  logic [HIST_W-1:0] hist_r;
  logic [HIST_W-1:0] hist_nxt;
  logic [3:0]        cnt_r;
  logic [3:0]        cnt_nxt;

  always_comb
  begin
    hist_nxt = hist_r;
    if (tick_i)
    begin
      hist_nxt = {hist_r[HIST_W-2:0], enabled_i};
    end
    cnt_nxt = 4'h0;
    for (int i = 0; i < HIST_W; i++)
    begin
      cnt_nxt = cnt_nxt + {3'h0, hist_nxt[i]};
    end
  end

  // all-ones at reset so the limit starts at its highest
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      hist_r <= {HIST_W{1'b1}};
      cnt_r  <= 4'h8;
    end
    else
    begin
      hist_r <= hist_nxt;
      cnt_r  <= cnt_nxt;
    end
  end

  assign on_count_o = cnt_r;

endmodule
`default_nettype wire

// ### logic/ocs_pkg.sv
package ocs_pkg;

  // ==========================================================
  // clock and timing
  // ==========================================================
  localparam int CLK_MHZ          = 200;
  localparam int OSC_AVG_KHZ      = 100;
  localparam int OSC_JIT_PP_KHZ   = 6;
  localparam int OSC_MOD_HZ       = 1000;
  // period count: 200 MHz / 100 kHz
  localparam int PERIOD_CYC       = CLK_MHZ * 1000 / OSC_AVG_KHZ;
  // +/- half the p-p jitter, expressed in cycles
  localparam int JIT_CYC          = (PERIOD_CYC * OSC_JIT_PP_KHZ)
                                    / (2 * OSC_AVG_KHZ);
  // periods per jitter modulation sweep
  localparam int MOD_PERIODS      = OSC_AVG_KHZ * 1000 / OSC_MOD_HZ;
  // per-tick sweep step: a base step plus one extra on the first ticks
  localparam int HALF_SWEEP       = MOD_PERIODS / 2;
  localparam int JIT_STEP_BASE    = 2 * JIT_CYC / HALF_SWEEP;
  localparam int JIT_STEP_REM     = 2 * JIT_CYC - JIT_STEP_BASE * HALF_SWEEP;
  localparam int MAX_DUTY_PCT     = 64;
  localparam int MAX_ON_CYC       = PERIOD_CYC * MAX_DUTY_PCT / 100;
  // soa skip in tenths of a period (2.5 periods)
  localparam int SOA_SKIP_TENTHS  = 25;
  localparam int SOA_SKIP_CYC     = PERIOD_CYC * SOA_SKIP_TENTHS / 10;
  // output restart qualify time in microseconds
  localparam int RESTART_QUAL_US  = 50000;
  localparam int RESTART_QUAL_CYC = RESTART_QUAL_US * CLK_MHZ;
  localparam int CNT_W            = 24;

  // ==========================================================
  // current limit state machine
  // ==========================================================
  localparam int HIST_W           = 8;
  localparam int HIGH_ON_MIN      = 6;
  localparam int MED_ON_MIN       = 4;
  localparam int LOW_ON_MIN       = 2;

  typedef enum logic [3:0] {
    LIM_LIGHTEST = 4'h1,
    LIM_LOW      = 4'h2,
    LIM_MEDIUM   = 4'h4,
    LIM_HIGHEST  = 4'h8
  } ocs_lim_t;

  // ==========================================================
  // cycle phase
  // ==========================================================
  typedef enum logic [2:0] {
    PH_IDLE = 3'h1,
    PH_ON   = 3'h2,
    PH_SR   = 3'h4
  } ocs_phase_t;

endpackage

// ### sim/ocs_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module ocs_monitor
  import ocs_pkg::*;
(
  // clock and reset
  input wire logic       clk_i,
  input wire logic       reset_n_i,
  // inputs watched
  input wire logic       current_limit_i,
  input wire logic       current_sense_surge_i,
  input wire logic       sr_drop_below_i,
  input wire logic       forward_winding_negedge_i,
  // outputs watched
  input wire logic       power_switch_gate_o,
  input wire logic       sync_rectifier_gate_o,
  input wire logic [3:0] limit_state_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // ====================
  // on-time counter
  logic [11:0] on_r;
  logic [11:0] on_nxt;
  always_comb on_nxt = power_switch_gate_o ? on_r + 12'h001 : 12'h000;
  always_ff @(posedge clk_i or negedge reset_n_i)
    if (!reset_n_i) on_r <= 12'h000;
    else on_r <= on_nxt;
  // ====================
  // sequences
  sequence s_cut;
    power_switch_gate_o && current_limit_i;
  endsequence
  sequence s_drop;
    sync_rectifier_gate_o && sr_drop_below_i;
  endsequence
  // ====================
  // assertions
  chk_limit_onehot: assert property ($onehot(limit_state_o))
    else $error("limit state not one-hot");
  chk_no_overlap: assert property (
    !(power_switch_gate_o && sync_rectifier_gate_o))
    else $error("switch and rectifier on together");
  chk_limit_cut: assert property (s_cut |=> !power_switch_gate_o)
    else $error("switch not cut by current limit");
  chk_max_duty: assert property (on_r <= MAX_ON_CYC)
    else $error("on-time past duty limit");
  chk_surge_off: assert property (
    current_sense_surge_i |=> !sync_rectifier_gate_o)
    else $error("rectifier on during surge");
  chk_drop_off: assert property (s_drop |=> !sync_rectifier_gate_o)
    else $error("rectifier not off on drop");
  chk_sr_cause: assert property (
    $rose(sync_rectifier_gate_o) |-> $past(forward_winding_negedge_i))
    else $error("rectifier on without forward edge");
  chk_limit_start: assert property (
    !$stable(limit_state_o) |-> $rose(power_switch_gate_o))
    else $error("limit changed outside cycle start");
endmodule
bind ocs_cycle_ctrl ocs_monitor u_mon (.clk_i, .reset_n_i,
  .current_limit_i, .current_sense_surge_i, .sr_drop_below_i,
  .forward_winding_negedge_i, .power_switch_gate_o,
  .sync_rectifier_gate_o, .limit_state_o);
`default_nettype wire

// ### sim/ocs_stage_model.sv
`timescale 1ns/1ps
`default_nettype none
module ocs_stage_model
(
  // clock
  input wire logic        clk_i,
  // switch and knobs
  input wire logic        gate_i,
  input wire logic [11:0] ilim_i,
  input wire logic [11:0] drop_i,
  // events back
  output logic            lim_o,
  output logic            neg_o,
  output logic            drop_o
);
  int   on_n   = 0;
  int   off_n  = 0;
  logic gate_q = 1'b0;
  initial {lim_o, neg_o, drop_o} = 3'h0;
  // ilim 0: current never reaches limit; drop 0: continuous conduction
  always @(posedge clk_i)
  begin
    gate_q <= gate_i;
    on_n   <= gate_i ? on_n + 1 : 0;
    off_n  <= gate_i ? 0 : off_n + 1;
    lim_o  <= gate_i && ilim_i != 0 && on_n + 1 >= ilim_i;
    // winding flies back as the switch opens
    neg_o  <= gate_q && !gate_i;
    drop_o <= !gate_i && drop_i != 0 && off_n + 1 >= drop_i;
  end
endmodule
`default_nettype wire

// ### sim/test_onoff_cycle_skip_controller.sv
`timescale 1ns/1ps
`default_nettype none
module test_onoff_cycle_skip_controller;
  import ocs_pkg::*;
  logic        clk_i = 1'b0, reset_n_i = 1'b0, trk = 1'b1;
  logic        vlow = 1'b0, rlow = 1'b0, cc = 1'b0, cp = 1'b0;
  logic        over = 1'b0, surge = 1'b0, blank = 1'b0;
  logic [11:0] ilim = 12'h064, drop = 12'h000;
  wire logic   lim, neg, dropb, gate, srg, rst_o;
  wire logic [3:0] lst;
  int          n_mismatch = 0, check_count = 0, now_c = 0, last_c = 0;
  int          gap, wid, c0, c1, hist[$];
  always #2.5 clk_i = ~clk_i;
  always @(posedge clk_i) now_c <= now_c + 1;
  ocs_cycle_ctrl #(.RESTART_QUAL_CYC_P(100)) dut (.clk_i, .reset_n_i,
    .output_voltage_sense_low_i(vlow), .output_restart_low_i(rlow),
    .below_cc_knee_i(cc), .above_power_knee_i(cp),
    .current_sense_over_i(over), .current_sense_surge_i(surge),
    .sr_drop_below_i(dropb), .current_limit_i(lim),
    .limit_in_blank_i(blank), .forward_winding_negedge_i(neg),
    .power_switch_gate_o(gate), .sync_rectifier_gate_o(srg),
    .limit_state_o(lst), .restart_o(rst_o));
  ocs_stage_model stage (.clk_i, .gate_i(gate), .ilim_i(ilim),
    .drop_i(drop), .lim_o(lim), .neg_o(neg), .drop_o(dropb));
  // ====================
  // helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD %0t saw %0h want %0h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  function automatic logic [3:0] lmap(input int c);
    if (c >= HIGH_ON_MIN) return 4'h8;
    if (c >= MED_ON_MIN) return 4'h4;
    return (c >= LOW_ON_MIN) ? 4'h2 : 4'h1;
  endfunction
  function automatic int on8();
    int s;
    s = 0;
    foreach (hist[i])
      if (i + 8 >= hist.size()) s += hist[i];
    return s;
  endfunction
  // one period: wait for the switch, time its on-width
  task automatic pulse(input int max, input bit flip);
    int n;
    n = 0;
    wid = 0;
    while (gate !== 1'b0) step(1);
    while (gate !== 1'b1 && n < max)
    begin
      step(1);
      n++;
    end
    gap = now_c - last_c;
    last_c = now_c;
    if (gate === 1'b1)
    begin
      check(srg, 1'b0);
      c0 = on8();
      hist.push_back(1);
      c1 = on8();
      // skip when the window edge makes the count ambiguous
      if (trk && lmap(c0) === lmap(c1)) check(lst, lmap(c1));
    end
    while (gate === 1'b1)
    begin
      @(posedge clk_i);
      if (flip && wid == 20) vlow <= 1'b0;
      #1 wid++;
    end
  endtask
  task automatic rises(input int n, output int c);
    logic p;
    c = 0;
    p = gate;
    repeat (n)
    begin
      step(1);
      if (gate === 1'b1 && p !== 1'b1) c++;
      p = gate;
    end
  endtask
  task automatic finish_test();
    if (n_mismatch == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ====================
  // sequence
  initial
  begin
    void'($urandom(46415));
    step(11);
    check({gate, srg, rst_o, lst}, 7'h08);
    @(posedge clk_i) reset_n_i <= 1'b1;
    step(1);
    check({gate, srg, rst_o, lst}, 7'h08);
    repeat (9) hist.push_back(0);
    pulse(18500, 0);
    check(wid, 0);
    @(posedge clk_i) vlow <= 1'b1;
    for (int i = 0; i < 12; i++)
    begin
      @(posedge clk_i);
      ilim <= (i == 5) ? 12'h000 : 12'(40 + $urandom % 400);
      drop <= (i == 7 || i == 9) ? 12'h000 : 12'(10 + $urandom % 200);
      pulse(2200, i == 3);
      @(posedge clk_i) vlow <= 1'b1;
      if (i > 0) check(gap >= 1940 && gap <= 2060, 1'b1);
      c0 = (ilim == 0) ? MAX_ON_CYC : ilim + 1;
      check(wid >= c0 - 1 && wid <= c0 + 1, 1'b1);
      step(2);
      check(srg, 1'b1);
      if (i == 9)
      begin
        @(posedge clk_i) surge <= 1'b1;
        step(2);
        check(srg, 1'b0);
        @(posedge clk_i) surge <= 1'b0;
      end
      else if (drop == 0)
      begin
        step(1200);
        check(srg, 1'b1);
      end
      else
      begin
        step(drop + 3);
        check(srg, 1'b0);
      end
    end
    trk = 1'b0;
    @(posedge clk_i);
    blank <= 1'b1;
    ilim <= 12'h020;
    pulse(2200, 0);
    pulse(2200, 0);
    @(posedge clk_i) blank <= 1'b0;
    pulse(8000, 0);
    check(gap > SOA_SKIP_CYC, 1'b1);
    for (int m = 0; m < 3; m++)
    begin
      @(posedge clk_i);
      over <= (m < 2);
      cc <= (m == 0);
      cp <= (m == 1);
      rises(8300, c0);
      check(m < 2 ? c0 >= 1 && c0 <= 3 : c0 >= 4, 1'b1);
    end
    @(posedge clk_i) rlow <= 1'b1;
    step(150);
    check(rst_o, 1'b1);
    rises(4200, c0);
    check(c0, 0);
    @(posedge clk_i) rlow <= 1'b0;
    step(3);
    check(rst_o, 1'b0);
    finish_test();
  end
  initial
  begin
    // tests take about 81k cycles; stop at 96k
    #(96000 * 5);
    n_mismatch++;
    finish_test();
  end
endmodule
`default_nettype wire
